//--- fwr_pkg.sv
`default_nettype none
package fwr_pkg;
  // clock and sampling timebase
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SAMPLE_60_NS = 1040000;
  localparam int unsigned SAMPLE_50_NS = 1250000;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned SAMPLE_60_CYCLES = SAMPLE_60_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_50_CYCLES = SAMPLE_50_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLES_PER_CYCLE = 16;

  // durations are carried in milliseconds
  localparam int unsigned MS_W = 13;
  localparam logic [12:0] PRE_MIN_MS = 13'h0032;
  localparam logic [12:0] PRE_MAX_MS = 13'h01f4;
  localparam logic [12:0] PRE_DEF_MS = 13'h0064;
  localparam logic [12:0] TAIL_MIN_MS = 13'h0032;
  localparam logic [12:0] TAIL_MAX_MS = 13'h01f4;
  localparam logic [12:0] TAIL_DEF_MS = 13'h0064;
  localparam logic [12:0] MAXLEN_MIN_MS = 13'h012c;
  localparam logic [12:0] MAXLEN_MAX_MS = 13'h1388;
  localparam logic [12:0] MAXLEN_DEF_MS = 13'h03e8;
  localparam logic [12:0] EXT_MIN_MS = 13'h0064;
  localparam logic [12:0] EXT_MAX_MS = 13'h1388;
  localparam logic [12:0] EXT_DEF_MS = 13'h01f4;
  localparam logic [12:0] EXT_INFINITE = 13'h0000;
  localparam logic [13:0] STORE_TOTAL_MS = 14'h1388;

  // record directory
  localparam int unsigned NUM_RECORDS = 8;
  localparam logic [3:0] NUM_RECORDS_C = 4'h8;
  localparam int unsigned ADDR_W = 13;

  // capture_trigger_mode codes
  localparam logic [1:0] MODE_SAVE_PICKUP = 2'h0;
  localparam logic [1:0] MODE_SAVE_TRIP = 2'h1;
  localparam logic [1:0] MODE_START_TRIP = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PROT, ST_TAIL, ST_EXT, ST_EVICT, ST_WRITE
  } fwr_state_t;

  // limit a setting into its legal range
  function automatic logic [12:0] fwr_clamp(input logic [12:0] v, input logic [12:0] lo,
                                            input logic [12:0] hi);
    fwr_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage
`default_nettype wire

//--- fwr_pin_sync.sv
`default_nettype none
module fwr_pin_sync #(
  parameter int unsigned W = 2
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } fwr_sync_regs_t;

  fwr_sync_regs_t r_reg;
  fwr_sync_regs_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = i_pin;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < int'(W); i++) begin
      // accept a change only once two later stages agree
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.lvl[i] = r_reg.s3[i];
      end
      r_next.rise[i] = (r_reg.s2[i] == r_reg.s3[i]) && r_reg.s3[i] && !r_reg.lvl[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_level = r_reg.lvl;
  assign o_rise = r_reg.rise;
endmodule // fwr_pin_sync
`default_nettype wire

//--- fwr_recorder.sv
`default_nettype none
module fwr_recorder
  import fwr_pkg::*;
#(
  parameter int unsigned P_SAMPLE_60_CYCLES = SAMPLE_60_CYCLES,
  parameter int unsigned P_SAMPLE_50_CYCLES = SAMPLE_50_CYCLES,
  parameter int unsigned P_MS_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // settings
  input wire logic I_RECORDER_ENABLE,
  input wire logic [1:0] I_CAPTURE_TRIGGER_MODE,
  input wire logic I_SYSTEM_SCOPE,
  input wire logic I_FREQ_50,
  input wire logic [12:0] I_PRE_TIME_MS,
  input wire logic [12:0] I_TAIL_TIME_MS,
  input wire logic [12:0] I_MAX_LENGTH_MS,
  input wire logic [12:0] I_EXTERNAL_RECORD_TIME_MS,
  // protection side, same clock
  input wire logic I_PICKUP,
  input wire logic I_TRIP,
  input wire logic I_RECLOSE_BUSY,
  // external triggers, asynchronous pins
  input wire logic I_BINARY_TRIGGER,
  input wire logic I_PC_TRIGGER,
  // sample store
  output logic O_SAMPLE_STROBE,
  output logic [12:0] O_WRITE_ADDR,
  // status
  output logic O_RECORD_ACTIVE,
  output logic O_RECORD_SAVED,
  output logic O_WAVE_DELETED,
  output logic [3:0] O_RECORD_COUNT,
  output logic [13:0] O_TOTAL_MS,
  output logic [12:0] O_LAST_START_ADDR,
  output logic [12:0] O_LAST_PRE_MS,
  output logic [12:0] O_LAST_LEN_MS
);
  typedef struct packed {
    fwr_state_t st;
    logic [17:0] smp_cnt;
    logic [17:0] ms_cnt;
    logic ms_tick;
    logic smp_strobe;
    logic [12:0] wr_addr;
    logic pick_d;
    logic trip_d;
    logic pend;
    logic saw_trip;
    logic ext_rec;
    logic [12:0] rec_ms;
    logic [12:0] tail_cnt;
    logic [12:0] trig_addr;
    logic [12:0] pre_ms;
    logic [12:0] len_ms;
    logic [2:0] head;
    logic [3:0] count;
    logic [13:0] total_ms;
    logic [NUM_RECORDS-1:0][12:0] dir_start;
    logic [NUM_RECORDS-1:0][12:0] dir_pre;
    logic [NUM_RECORDS-1:0][12:0] dir_len;
    logic [12:0] last_start;
    logic [12:0] last_pre;
    logic [12:0] last_len;
    logic active;
    logic saved;
    logic deleted;
  } fwr_regs_t;

  fwr_regs_t r_reg;
  fwr_regs_t r_next;
  logic [1:0] ext_level;
  logic [1:0] ext_rise;

  fwr_pin_sync #(.W(2)) u_pin_sync (
    .i_clk(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_pin({I_PC_TRIGGER, I_BINARY_TRIGGER}),
    .o_level(ext_level),
    .o_rise(ext_rise)
  );

  logic [12:0] pre_set;
  logic [12:0] pre_cap;
  logic [12:0] tail_set;
  logic [12:0] max_set;
  logic [12:0] ext_set;
  logic crit;
  logic crit_rise;
  logic ext_edge;
  logic at_max;
  logic [13:0] sum_ms;
  logic [2:0] wr_idx;

  always_comb begin
    pre_set = fwr_clamp(I_PRE_TIME_MS, PRE_MIN_MS, PRE_MAX_MS);
    tail_set = fwr_clamp(I_TAIL_TIME_MS, TAIL_MIN_MS, TAIL_MAX_MS);
    max_set = fwr_clamp(I_MAX_LENGTH_MS, MAXLEN_MIN_MS, MAXLEN_MAX_MS);
    // lead-in may not by itself exceed the maximum length
    pre_cap = (pre_set > max_set) ? max_set : pre_set;
    ext_set = (I_EXTERNAL_RECORD_TIME_MS == EXT_INFINITE) ? EXT_INFINITE :
              fwr_clamp(I_EXTERNAL_RECORD_TIME_MS, EXT_MIN_MS, EXT_MAX_MS);
    crit = (I_CAPTURE_TRIGGER_MODE == MODE_START_TRIP) ? I_TRIP : I_PICKUP;
    crit_rise = (I_CAPTURE_TRIGGER_MODE == MODE_START_TRIP) ? (I_TRIP && !r_reg.trip_d) :
                (I_PICKUP && !r_reg.pick_d);
    ext_edge = |ext_rise;
    at_max = ({1'b0, r_reg.pre_ms} + {1'b0, r_reg.rec_ms}) >= {1'b0, max_set};
    sum_ms = r_reg.total_ms + {1'b0, r_reg.len_ms};
    wr_idx = r_reg.head + r_reg.count[2:0];
  end

  always_comb begin
    r_next = r_reg;
    r_next.saved = 1'b0;
    r_next.deleted = 1'b0;
    r_next.pick_d = I_PICKUP;
    r_next.trip_d = I_TRIP;
    r_next.smp_strobe = (r_reg.smp_cnt == 18'h0);
    if (r_reg.smp_cnt == 18'h0) begin
      r_next.smp_cnt = I_FREQ_50 ? 18'(P_SAMPLE_50_CYCLES - 1) : 18'(P_SAMPLE_60_CYCLES - 1);
    end else begin
      r_next.smp_cnt = r_reg.smp_cnt - 18'h1;
    end
    if (r_reg.smp_strobe) begin
      r_next.wr_addr = r_reg.wr_addr + 13'h1;
    end
    r_next.ms_tick = (r_reg.ms_cnt == 18'h0);
    r_next.ms_cnt = (r_reg.ms_cnt == 18'h0) ? 18'(P_MS_CYCLES - 1) : r_reg.ms_cnt - 18'h1;
    if (r_reg.ms_tick && (r_reg.st == ST_PROT || r_reg.st == ST_TAIL || r_reg.st == ST_EXT)) begin
      r_next.rec_ms = r_reg.rec_ms + 13'h1;
    end
    // a protection trigger edge seen while busy is kept for later; a take in the state case below wins over a new edge
    if (r_reg.st != ST_IDLE && crit_rise && I_RECORDER_ENABLE) begin
      r_next.pend = 1'b1;
    end
    if (I_TRIP) begin
      r_next.saw_trip = 1'b1;
    end
    case (r_reg.st)
      ST_IDLE: begin
        r_next.pend = 1'b0;
        if (!I_RECORDER_ENABLE) begin
          r_next.st = ST_IDLE;
        end else if (ext_edge) begin
          r_next.st = ST_EXT;
          r_next.ext_rec = 1'b1;
          r_next.pre_ms = 13'h0;
          r_next.rec_ms = 13'h0;
          r_next.trig_addr = r_reg.wr_addr;
        end else if (crit_rise || r_reg.pend) begin
          r_next.st = ST_PROT;
          r_next.ext_rec = 1'b0;
          r_next.pre_ms = pre_cap;
          r_next.rec_ms = 13'h0;
          r_next.trig_addr = r_reg.wr_addr;
          r_next.saw_trip = I_TRIP;
        end
      end
      ST_PROT: begin
        if (at_max) begin
          r_next.st = ST_EVICT;
        end else if (!crit) begin
          r_next.st = ST_TAIL;
          r_next.tail_cnt = 13'h0;
        end
      end
      ST_TAIL: begin
        if (at_max) begin
          r_next.st = ST_EVICT;
        end else if (crit_rise && I_SYSTEM_SCOPE) begin
          r_next.st = ST_PROT;
          // the edge is used up here, so it must not start a second record
          r_next.pend = 1'b0;
        end else if (crit_rise) begin
          r_next.st = ST_EVICT;
        end else if (I_SYSTEM_SCOPE && I_RECLOSE_BUSY) begin
          r_next.tail_cnt = 13'h0;
        end else if (r_reg.ms_tick) begin
          r_next.tail_cnt = r_reg.tail_cnt + 13'h1;
          if (r_reg.tail_cnt + 13'h1 >= tail_set) begin
            r_next.st = ST_EVICT;
          end
        end
        if (r_next.st == ST_EVICT && I_CAPTURE_TRIGGER_MODE == MODE_SAVE_TRIP &&
            !r_reg.saw_trip && !I_TRIP) begin
          r_next.st = ST_IDLE;
        end
      end
      ST_EXT: begin
        if (at_max || (ext_set != EXT_INFINITE && r_reg.rec_ms >= ext_set)) begin
          r_next.st = ST_EVICT;
        end else if (ext_set == EXT_INFINITE && !ext_level[0]) begin
          r_next.st = ST_EVICT;
        end
      end
      ST_EVICT: begin
        r_next.len_ms = r_reg.pre_ms + r_reg.rec_ms;
        if (r_reg.count != 4'h0 && (r_reg.count == NUM_RECORDS_C ||
            r_reg.total_ms + {1'b0, r_reg.pre_ms + r_reg.rec_ms} > STORE_TOTAL_MS)) begin
          r_next.total_ms = r_reg.total_ms - {1'b0, r_reg.dir_len[r_reg.head]};
          r_next.head = r_reg.head + 3'h1;
          r_next.count = r_reg.count - 4'h1;
          r_next.deleted = 1'b1;
        end else begin
          r_next.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        r_next.dir_start[wr_idx] = r_reg.trig_addr;
        r_next.dir_pre[wr_idx] = r_reg.pre_ms;
        r_next.dir_len[wr_idx] = r_reg.len_ms;
        r_next.last_start = r_reg.trig_addr;
        r_next.last_pre = r_reg.pre_ms;
        r_next.last_len = r_reg.len_ms;
        r_next.count = r_reg.count + 4'h1;
        r_next.total_ms = sum_ms;
        r_next.saved = 1'b1;
        r_next.st = ST_IDLE;
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    r_next.active = r_next.ext_rec ? (r_next.st == ST_EXT) :
                    (r_next.st == ST_PROT || r_next.st == ST_TAIL);
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign O_SAMPLE_STROBE = r_reg.smp_strobe;
  assign O_WRITE_ADDR = r_reg.wr_addr;
  assign O_RECORD_ACTIVE = r_reg.active;
  assign O_RECORD_SAVED = r_reg.saved;
  assign O_WAVE_DELETED = r_reg.deleted;
  assign O_RECORD_COUNT = r_reg.count;
  assign O_TOTAL_MS = r_reg.total_ms;
  assign O_LAST_START_ADDR = r_reg.last_start;
  assign O_LAST_PRE_MS = r_reg.last_pre;
  assign O_LAST_LEN_MS = r_reg.last_len;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);

  sequence seq_tail_retrig;
    r_reg.st == ST_TAIL && !at_max && crit_rise;
  endsequence

  AST_DISABLED_IDLE: assert property (
    !I_RECORDER_ENABLE && r_reg.st == ST_IDLE |=> r_reg.st == ST_IDLE)
    else $error("recording started while disabled");
  AST_PICKUP_START: assert property (
    I_RECORDER_ENABLE && r_reg.st == ST_IDLE && !ext_edge &&
    I_CAPTURE_TRIGGER_MODE == MODE_SAVE_PICKUP && I_PICKUP && !r_reg.pick_d
    |=> r_reg.st == ST_PROT ##0 r_reg.pre_ms == pre_cap)
    else $error("pickup did not start a record");
  AST_TRIP_START: assert property (
    I_RECORDER_ENABLE && r_reg.st == ST_IDLE && !ext_edge &&
    I_CAPTURE_TRIGGER_MODE == MODE_START_TRIP && I_TRIP && !r_reg.trip_d
    |=> r_reg.st == ST_PROT)
    else $error("trip did not start a record");
  AST_NO_TRIP_DISCARD: assert property (
    r_reg.st == ST_TAIL && r_next.st == ST_IDLE |=> !r_reg.saved [*2])
    else $error("record kept without trip");
  AST_PER_FAULT_SPLIT: assert property (
    seq_tail_retrig ##0 !I_SYSTEM_SCOPE && I_CAPTURE_TRIGGER_MODE != MODE_SAVE_TRIP
    |=> r_reg.st == ST_EVICT ##[2:10] r_reg.saved)
    else $error("per-fault retrigger did not close the record");
  AST_SYSTEM_CONTINUE: assert property (
    seq_tail_retrig ##0 I_SYSTEM_SCOPE |=> r_reg.st == ST_PROT)
    else $error("system scope split the record");
  AST_MAX_LENGTH: assert property (
    r_reg.st == ST_WRITE |-> r_reg.len_ms <= max_set)
    else $error("record longer than maximum");
  AST_STORE_LIMIT: assert property (
    r_reg.count <= NUM_RECORDS_C && r_reg.total_ms <= STORE_TOTAL_MS)
    else $error("store limits exceeded");
  AST_EVICT_FLAG: assert property (
    r_reg.st == ST_EVICT && r_reg.count == NUM_RECORDS_C
    |=> O_WAVE_DELETED && $past(r_reg.head) + 3'h1 == r_reg.head)
    else $error("full store did not drop oldest");
  AST_EXT_NO_LEAD: assert property (
    r_reg.st == ST_IDLE && I_RECORDER_ENABLE && ext_edge
    |=> r_reg.st == ST_EXT && r_reg.pre_ms == 13'h0)
    else $error("external trigger mishandled");
  AST_SAMPLE_GAP: assert property (
    O_SAMPLE_STROBE |=> !O_SAMPLE_STROBE [*8])
    else $error("sample strobes too close");
endmodule // fwr_recorder
`default_nettype wire

//--- fwr_prot_model.sv
`default_nettype none
module fwr_prot_model #(
  parameter int unsigned MSC = 20
) (
  input wire logic i_clk,
  output logic o_pickup,
  output logic o_trip,
  output logic o_bin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_pickup = 1'b0;
    o_trip = 1'b0;
    o_bin = 1'b0;
  end
  task automatic fault(input int ms, input logic pk, input logic tr);
    @(negedge i_clk);
    o_pickup = pk;
    o_trip = tr;
    repeat (ms * MSC) @(negedge i_clk);
    o_pickup = 1'b0;
    o_trip = 1'b0;
  endtask
  task automatic bin_hold(input int ms);
    @(negedge i_clk);
    o_bin = 1'b1;
    repeat (ms * MSC) @(negedge i_clk);
    o_bin = 1'b0;
  endtask
endmodule // fwr_prot_model
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top
  import fwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 20;
  localparam logic [1:0] MT[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [5:0] PK = 6'h2f;
  localparam logic [5:0] TR = 6'h14;
  localparam logic [5:0] SV = 6'h35;
  logic clk, arst_n, en, scope, busy, f50, pc, pickup, trip, bin;
  logic [1:0] mode;
  logic [12:0] pre_ms, tail_ms, max_ms, ext_ms, waddr, lstart, lpre, llen;
  logic strobe, active, saved, deleted;
  logic [3:0] count;
  logic [13:0] total;
  int failures = 0;
  int compares = 0;
  int saves = 0;
  int deletes = 0;
  logic [31:0] seed = 32'h401000e4;

  fwr_recorder #(
    .P_SAMPLE_60_CYCLES(10),
    .P_SAMPLE_50_CYCLES(12),
    .P_MS_CYCLES(MSC)
  ) fwr_recorder_i (
    .I_CLOCK(clk), .I_ARST_N(arst_n), .I_RECORDER_ENABLE(en),
    .I_CAPTURE_TRIGGER_MODE(mode), .I_SYSTEM_SCOPE(scope), .I_FREQ_50(f50),
    .I_PRE_TIME_MS(pre_ms), .I_TAIL_TIME_MS(tail_ms), .I_MAX_LENGTH_MS(max_ms),
    .I_EXTERNAL_RECORD_TIME_MS(ext_ms), .I_PICKUP(pickup), .I_TRIP(trip),
    .I_RECLOSE_BUSY(busy), .I_BINARY_TRIGGER(bin), .I_PC_TRIGGER(pc),
    .O_SAMPLE_STROBE(strobe), .O_WRITE_ADDR(waddr), .O_RECORD_ACTIVE(active),
    .O_RECORD_SAVED(saved), .O_WAVE_DELETED(deleted), .O_RECORD_COUNT(count),
    .O_TOTAL_MS(total), .O_LAST_START_ADDR(lstart), .O_LAST_PRE_MS(lpre),
    .O_LAST_LEN_MS(llen)
  );
  fwr_prot_model #(.MSC(MSC)) fwr_prot_model_i (
    .i_clk(clk), .o_pickup(pickup), .o_trip(trip), .o_bin(bin)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (saved === 1'b1) saves++;
    if (deleted === 1'b1) deletes++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  // ms counts may land up to two ticks either side of the ideal figure
  function automatic bit near(input logic [12:0] v, input int e);
    near = (int'(v) >= e - 2) && (int'(v) <= e + 2);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rec(output bit ok, input int lim);
    ok = 1'b0;
    for (int k = 0; k < lim && !ok; k++) begin
      @(negedge clk);
      ok = (saved === 1'b1);
    end
    @(negedge clk);
  endtask
  task automatic per(output int n, output logic [12:0] d);
    logic [12:0] a;
    for (int k = 0; k < 40 && strobe !== 1'b1; k++) @(negedge clk);
    a = waddr;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 40);
    d = waddr - a;
  endtask
  task automatic finish_test();
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    int h, s0;
    bit ok;
    logic [12:0] e;
    arst_n = 1'b0;
    {en, scope, busy, f50, pc} = 5'h00;
    mode = MODE_SAVE_PICKUP;
    pre_ms = PRE_DEF_MS;
    tail_ms = TAIL_MIN_MS;
    max_ms = MAXLEN_DEF_MS;
    ext_ms = EXT_DEF_MS;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(count, 4'h0);
    for (int i = 0; i < 2; i++) begin
      f50 = i[0];
      per(h, e);
      per(h, e);
      chk(h, i ? 12 : 10);
      chk(e, 13'h0001);
    end
    // a pickup while off must not save a record, even over a long idle
    fwr_prot_model_i.fault(2, 1'b1, 1'b0);
    wait_rec(ok, 510 * MSC);
    chk(ok, 0);
    en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      mode = MT[i];
      seed = xs(seed);
      h = 1 + int'(seed[15:0] % 20);
      pre_ms = (i == 0) ? 13'h0005 : 13'(50 + seed[31:16] % 451);
      e = (i == 0) ? PRE_MIN_MS : pre_ms;
      fwr_prot_model_i.fault(h, PK[i], TR[i]);
      wait_rec(ok, 80 * MSC);
      chk(ok, SV[i]);
      if (ok) begin
        chk(lpre, e);
        chk(near(llen, e + h + 50), 1);
      end
    end
    mode = MODE_SAVE_PICKUP;
    pre_ms = PRE_DEF_MS;
    for (int sc = 0; sc < 2; sc++) begin
      scope = sc[0];
      busy = sc[0];
      s0 = saves;
      fwr_prot_model_i.fault(3, 1'b1, 1'b0);
      repeat (5 * MSC) @(negedge clk);
      fwr_prot_model_i.fault(3, 1'b1, 1'b0);
      busy = 1'b0;
      repeat (90 * MSC) @(negedge clk);
      chk(saves - s0, 2 - sc);
    end
    scope = 1'b0;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      e = (i == 1) ? 13'h001e : 13'(100 + seed[7:0] % 100);
      ext_ms = (i == 1) ? EXT_INFINITE : e;
      if (i == 2) begin
        pc = 1'b1;
        repeat (MSC) @(negedge clk);
        pc = 1'b0;
      end else begin
        fwr_prot_model_i.bin_hold((i == 1) ? 30 : 2);
      end
      wait_rec(ok, 220 * MSC);
      chk(ok, 1);
      chk(lpre, 13'h0000);
      chk(near(llen, e), 1);
    end
    max_ms = MAXLEN_MIN_MS;
    fork
      fwr_prot_model_i.fault(400, 1'b1, 1'b0);
      wait_rec(ok, 400 * MSC);
    join
    chk(near(llen, 300), 1);
    max_ms = MAXLEN_DEF_MS;
    pre_ms = PRE_MIN_MS;
    for (int i = 0; i < 6; i++) begin
      fwr_prot_model_i.fault(1, 1'b1, 1'b0);
      wait_rec(ok, 80 * MSC);
      chk(total <= STORE_TOTAL_MS, 1);
    end
    chk(count, NUM_RECORDS_C);
    chk(deletes, saves - 8);
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
